// File: gpmc_pkg.sv
`default_nettype none
package gpmc_pkg;
   localparam int          CLK_HZ        = 20_000_000;
   localparam int          CLK_PERIOD_NS = 50;
   localparam int          BAUD_BPS      = 9600;
   localparam int          BIT_CYCLES    = CLK_HZ / BAUD_BPS;
   localparam int          HALF_CYCLES   = BIT_CYCLES / 2;
   localparam int          MS_NS         = 1_000_000;
   localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   localparam int          WARMUP_MIN    = 2;
   localparam int          WARMUP_MS     = WARMUP_MIN * 60_000;
   localparam logic [31:0] VND_HDR       = 32'h504D544B;
   localparam logic [7:0]  CH_START      = 8'h24;
   localparam logic [7:0]  CH_STAR       = 8'h2A;
   localparam logic [7:0]  CH_COMMA      = 8'h2C;
   localparam logic [7:0]  CH_CR         = 8'h0D;
   localparam logic [7:0]  CH_LF         = 8'h0A;
   localparam logic [31:0] CODE_STANDBY  = 32'h000000A1;
   localparam logic [31:0] CODE_PERIODIC = 32'h000000E1;
   localparam logic [31:0] ARG_EXIT      = 32'h00000000;
   localparam logic [31:0] ARG_FOREVER   = 32'h00000004;
   localparam logic [31:0] TYPE_BACKUP   = 32'h00000001;
   localparam logic [31:0] TYPE_STANDBY  = 32'h00000002;
   localparam logic [2:0]  LAST_FIELD    = 3'h5;

   typedef enum logic [2:0] {
      PM_OFF   = 3'b000,
      PM_FULL  = 3'b001,
      PM_STBY  = 3'b010,
      PM_BKUP  = 3'b011,
      PM_PWARM = 3'b100,
      PM_PON   = 3'b101,
      PM_PSLP  = 3'b110
   } gpmc_mode_e;

   typedef enum logic [2:0] {
      PS_IDLE = 3'b000,
      PS_HDR  = 3'b001,
      PS_FLD  = 3'b010,
      PS_CK1  = 3'b011,
      PS_CK2  = 3'b100,
      PS_CR   = 3'b101,
      PS_LF   = 3'b110
   } gpmc_parse_e;
endpackage
`default_nettype wire

// File: gpmc_top.sv
`timescale 1ns/1ps
`default_nettype none
module gpmc_top #(
   parameter int MS_CYCLES = gpmc_pkg::MS_CYCLES,
   parameter int WARMUP_MS  = gpmc_pkg::WARMUP_MS,
   parameter int BIT_CYCLES = gpmc_pkg::BIT_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic       uart_rx,
   input  wire logic       main_supply_ok,
   input  wire logic       backup_supply_ok,
   input  wire logic       host_supply_enable,
   input  wire logic       fix_valid,
   output logic            supply_switch_out,
   output logic            supply_switch_oe,
   output logic            rf_power_en,
   output logic            nav_en,
   output logic            nmea_en,
   output logic            rx_listen,
   output logic            aiding_reuse,
   output logic            fallback_active,
   output logic [2:0]      power_mode
);
   gpmc_pkg::gpmc_mode_e  mode_reg;
   gpmc_pkg::gpmc_parse_e ps_reg;
   logic [11:0] rx_cnt_reg;
   logic [3:0]  rx_bit_reg;
   logic        rx_busy_reg;
   logic [7:0]  rx_sh_reg;
   logic        rx_valid_reg;
   logic [31:0] ms_cnt_reg;
   logic        ms_tick_reg;
   logic [1:0]  hdr_idx_reg;
   logic [2:0]  fld_idx_reg;
   logic [31:0] fld_reg [0:5];
   logic [7:0]  ck_calc_reg;
   logic [7:0]  ck_rx_reg;
   logic        bad_reg;
   logic        cmd_reg;
   logic [31:0] iv_reg;
   logic [31:0] on_reg, sleep_reg, fb_on_reg, fb_sleep_reg;
   logic        per_bkup_reg;
   logic        forced_reg;
   logic        fb_reg;
   logic [7:0]  ch;
   logic        is_digit, is_hex;
   logic [3:0]  hex_val;
   logic        c_stby, c_exit, c_forever, c_per, sleep_bkup;

   assign ch       = rx_sh_reg;
   assign is_digit = ch >= 8'h30 && ch <= 8'h39;
   assign is_hex   = is_digit || (ch >= 8'h41 && ch <= 8'h46);
   assign hex_val  = is_digit ? 4'(ch - 8'h30) : 4'(ch - 8'h37);
   assign c_stby   = cmd_reg && fld_reg[0] == gpmc_pkg::CODE_STANDBY
                     && fld_idx_reg == 3'h1 && fld_reg[1] == gpmc_pkg::ARG_EXIT;
   assign c_exit   = cmd_reg && fld_reg[0] == gpmc_pkg::CODE_PERIODIC
                     && fld_idx_reg == 3'h1 && fld_reg[1] == gpmc_pkg::ARG_EXIT;
   assign c_forever = cmd_reg && fld_reg[0] == gpmc_pkg::CODE_PERIODIC
                     && fld_idx_reg == 3'h1
                     && fld_reg[1] == gpmc_pkg::ARG_FOREVER;
   assign c_per    = cmd_reg && fld_reg[0] == gpmc_pkg::CODE_PERIODIC
                     && fld_idx_reg == gpmc_pkg::LAST_FIELD
                     && (fld_reg[1] == gpmc_pkg::TYPE_BACKUP
                         || fld_reg[1] == gpmc_pkg::TYPE_STANDBY);
   assign sleep_bkup = mode_reg == gpmc_pkg::PM_PSLP && per_bkup_reg;

   // 8N1 receiver, sampled mid-bit; listens only while the mode allows
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rx_busy_reg  <= 1'b0;
         rx_cnt_reg   <= 12'h000;
         rx_bit_reg   <= 4'h0;
         rx_sh_reg    <= 8'h00;
         rx_valid_reg <= 1'b0;
      end else begin
         rx_valid_reg <= 1'b0;
         if (!rx_busy_reg) begin
            if (rx_listen && !uart_rx) begin
               rx_busy_reg <= 1'b1;
               rx_cnt_reg  <= 12'(BIT_CYCLES / 2);
               rx_bit_reg  <= 4'h0;
            end
         end else if (rx_cnt_reg != 12'h000) begin
            rx_cnt_reg <= rx_cnt_reg - 12'h001;
         end else begin
            rx_cnt_reg <= 12'(BIT_CYCLES - 1);
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h0 && uart_rx) begin
               rx_busy_reg <= 1'b0;  // glitch, not a start bit
            end else if (rx_bit_reg >= 4'h1 && rx_bit_reg <= 4'h8) begin
               rx_sh_reg <= {uart_rx, rx_sh_reg[7:1]};
            end else if (rx_bit_reg == 4'h9) begin
               rx_busy_reg  <= 1'b0;
               rx_valid_reg <= uart_rx;  // framing error drops the byte
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ps_reg      <= gpmc_pkg::PS_IDLE;
         hdr_idx_reg <= 2'h0;
         fld_idx_reg <= 3'h0;
         ck_calc_reg <= 8'h00;
         ck_rx_reg   <= 8'h00;
         bad_reg     <= 1'b0;
         cmd_reg     <= 1'b0;
         for (int i = 0; i < 6; i++) fld_reg[i] <= 32'h00000000;
      end else begin
         cmd_reg <= 1'b0;
         if (rx_valid_reg && ch == gpmc_pkg::CH_START) begin
            ps_reg      <= gpmc_pkg::PS_HDR;
            hdr_idx_reg <= 2'h0;
            fld_idx_reg <= 3'h0;
            ck_calc_reg <= 8'h00;
            bad_reg     <= 1'b0;
            for (int i = 0; i < 6; i++) fld_reg[i] <= 32'h00000000;
         end else if (rx_valid_reg) begin
            unique case (ps_reg)
               gpmc_pkg::PS_IDLE: ;
               gpmc_pkg::PS_HDR: begin
                  ck_calc_reg <= ck_calc_reg ^ ch;
                  hdr_idx_reg <= hdr_idx_reg + 2'h1;
                  if (ch != gpmc_pkg::VND_HDR[8*(3-hdr_idx_reg) +: 8])
                     ps_reg <= gpmc_pkg::PS_IDLE;
                  else if (hdr_idx_reg == 2'h3)
                     ps_reg <= gpmc_pkg::PS_FLD;
               end
               gpmc_pkg::PS_FLD: begin
                  if (ch == gpmc_pkg::CH_STAR) begin
                     ps_reg <= gpmc_pkg::PS_CK1;
                  end else begin
                     ck_calc_reg <= ck_calc_reg ^ ch;
                     if (ch == gpmc_pkg::CH_COMMA) begin
                        if (fld_idx_reg == gpmc_pkg::LAST_FIELD) bad_reg <= 1'b1;
                        else fld_idx_reg <= fld_idx_reg + 3'h1;
                     end else if (is_digit) begin
                        fld_reg[fld_idx_reg] <= 32'(fld_reg[fld_idx_reg] * 32'd10)
                                                + {24'h000000, ch - 8'h30};
                     end else begin
                        bad_reg <= 1'b1;
                     end
                  end
               end
               gpmc_pkg::PS_CK1: begin
                  ck_rx_reg[7:4] <= hex_val;
                  ps_reg <= is_hex ? gpmc_pkg::PS_CK2 : gpmc_pkg::PS_IDLE;
               end
               gpmc_pkg::PS_CK2: begin
                  ck_rx_reg[3:0] <= hex_val;
                  ps_reg <= is_hex ? gpmc_pkg::PS_CR : gpmc_pkg::PS_IDLE;
               end
               gpmc_pkg::PS_CR: begin
                  ps_reg <= ch == gpmc_pkg::CH_CR ? gpmc_pkg::PS_LF
                                                  : gpmc_pkg::PS_IDLE;
               end
               gpmc_pkg::PS_LF: begin
                  ps_reg  <= gpmc_pkg::PS_IDLE;
                  cmd_reg <= ch == gpmc_pkg::CH_LF && !bad_reg
                             && ck_rx_reg == ck_calc_reg;
               end
               default: ps_reg <= gpmc_pkg::PS_IDLE;
            endcase
         end
      end
   end

   // millisecond tick; in periodic backup it stands in for the always-on timer
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ms_cnt_reg  <= 32'h00000000;
         ms_tick_reg <= 1'b0;
      end else begin
         ms_tick_reg <= ms_cnt_reg == 32'(MS_CYCLES - 1);
         ms_cnt_reg  <= ms_cnt_reg == 32'(MS_CYCLES - 1) ? 32'h00000000
                                                       : ms_cnt_reg + 32'h1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode_reg     <= gpmc_pkg::PM_OFF;
         iv_reg       <= 32'h00000000;
         on_reg       <= 32'h00000000;
         sleep_reg    <= 32'h00000000;
         fb_on_reg    <= 32'h00000000;
         fb_sleep_reg <= 32'h00000000;
         per_bkup_reg <= 1'b0;
         forced_reg   <= 1'b0;
         fb_reg       <= 1'b0;
      end else begin
         if (ms_tick_reg && iv_reg != 32'h00000000) iv_reg <= iv_reg - 32'h1;
         if (!main_supply_ok && !backup_supply_ok) begin
            mode_reg <= gpmc_pkg::PM_OFF;
            // main power lags the release of our own switch: not a loss
         end else if (!main_supply_ok && !sleep_bkup && !supply_switch_oe
                      && mode_reg != gpmc_pkg::PM_BKUP) begin
            mode_reg <= gpmc_pkg::PM_BKUP;
         end else begin
            unique case (mode_reg)
               gpmc_pkg::PM_OFF: begin
                  if (main_supply_ok && backup_supply_ok) begin
                     mode_reg   <= gpmc_pkg::PM_FULL;
                     forced_reg <= 1'b0;
                     fb_reg     <= 1'b0;
                  end
               end
               gpmc_pkg::PM_FULL: begin
                  if (c_stby) begin
                     mode_reg <= gpmc_pkg::PM_STBY;
                  end else if (c_forever) begin
                     mode_reg   <= gpmc_pkg::PM_BKUP;
                     forced_reg <= 1'b1;
                  end else if (c_per) begin
                     mode_reg     <= gpmc_pkg::PM_PWARM;
                     iv_reg       <= 32'(WARMUP_MS);
                     per_bkup_reg <= fld_reg[1] == gpmc_pkg::TYPE_BACKUP;
                     on_reg       <= fld_reg[2];
                     sleep_reg    <= fld_reg[3];
                     fb_on_reg    <= fld_reg[4];
                     fb_sleep_reg <= fld_reg[5];
                     fb_reg       <= 1'b0;
                  end
               end
               gpmc_pkg::PM_STBY: begin
                  if (rx_valid_reg) mode_reg <= gpmc_pkg::PM_FULL;
               end
               gpmc_pkg::PM_BKUP: begin
                  // forced backup ends only when the host restores the supply
                  if (main_supply_ok && (!forced_reg || host_supply_enable)) begin
                     mode_reg   <= gpmc_pkg::PM_FULL;
                     forced_reg <= 1'b0;
                  end
               end
               gpmc_pkg::PM_PWARM: begin
                  if (c_exit) begin
                     mode_reg <= gpmc_pkg::PM_FULL;
                  end else if (iv_reg == 32'h00000000) begin
                     mode_reg <= gpmc_pkg::PM_PON;
                     iv_reg   <= on_reg;
                  end
               end
               gpmc_pkg::PM_PON: begin
                  if (fix_valid && fb_reg) fb_reg <= 1'b0;
                  if (c_exit) begin
                     mode_reg <= gpmc_pkg::PM_FULL;
                  end else if (iv_reg == 32'h00000000) begin
                     mode_reg <= gpmc_pkg::PM_PSLP;
                     fb_reg   <= !fix_valid;
                     iv_reg   <= fix_valid ? sleep_reg : fb_sleep_reg;
                  end
               end
               gpmc_pkg::PM_PSLP: begin
                  if (c_exit) begin
                     mode_reg <= gpmc_pkg::PM_FULL;
                  end else if (iv_reg == 32'h00000000) begin
                     mode_reg <= gpmc_pkg::PM_PON;
                     iv_reg   <= fb_reg ? fb_on_reg : on_reg;
                  end
               end
               default: mode_reg <= gpmc_pkg::PM_OFF;
            endcase
         end
      end
   end

   // outputs follow the mode one clock later
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         supply_switch_out <= 1'b0;
         supply_switch_oe  <= 1'b0;
         rf_power_en       <= 1'b0;
         nav_en            <= 1'b0;
         nmea_en           <= 1'b0;
         rx_listen         <= 1'b0;
         aiding_reuse      <= 1'b0;
         fallback_active   <= 1'b0;
         power_mode        <= 3'h0;
      end else begin
         supply_switch_out <= 1'b0;
         supply_switch_oe  <= (mode_reg == gpmc_pkg::PM_BKUP && forced_reg)
                              || sleep_bkup;
         rf_power_en <= mode_reg == gpmc_pkg::PM_FULL
                        || mode_reg == gpmc_pkg::PM_PWARM
                        || mode_reg == gpmc_pkg::PM_PON;
         nav_en      <= mode_reg == gpmc_pkg::PM_FULL
                        || mode_reg == gpmc_pkg::PM_PWARM
                        || mode_reg == gpmc_pkg::PM_PON;
         nmea_en     <= mode_reg == gpmc_pkg::PM_FULL
                        || mode_reg == gpmc_pkg::PM_PWARM
                        || mode_reg == gpmc_pkg::PM_PON;
         rx_listen   <= mode_reg != gpmc_pkg::PM_OFF
                        && mode_reg != gpmc_pkg::PM_BKUP
                        && !sleep_bkup;
         aiding_reuse <= mode_reg == gpmc_pkg::PM_FULL
                         && ($past(mode_reg) == gpmc_pkg::PM_STBY
                             || $past(mode_reg) == gpmc_pkg::PM_BKUP)
                         && !aiding_reuse;
         fallback_active <= fb_reg;
         power_mode      <= mode_reg;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   property p_power_on;
      mode_reg == gpmc_pkg::PM_OFF && main_supply_ok && backup_supply_ok
      |=> mode_reg == gpmc_pkg::PM_FULL ##1 rf_power_en;
   endproperty
   a_power_on: assert property (p_power_on) else $error("no full-on at power");
   property p_standby_entry;
      mode_reg == gpmc_pkg::PM_FULL && c_stby && main_supply_ok
      |=> mode_reg == gpmc_pkg::PM_STBY ##1 (!rf_power_en && !nmea_en && rx_listen);
   endproperty
   a_standby_entry: assert property (p_standby_entry) else $error("standby entry");
   property p_wake;
      mode_reg == gpmc_pkg::PM_STBY && rx_valid_reg && main_supply_ok
      |=> mode_reg == gpmc_pkg::PM_FULL ##1 aiding_reuse;
   endproperty
   a_wake: assert property (p_wake) else $error("byte did not wake standby");
   property p_backup_entry;
      !main_supply_ok && backup_supply_ok && !sleep_bkup && !supply_switch_oe
      |=> mode_reg == gpmc_pkg::PM_BKUP;
   endproperty
   a_backup_entry: assert property (p_backup_entry) else $error("no backup");
   property p_open_drain;
      supply_switch_oe |-> !supply_switch_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("switch driven high");
   property p_forever;
      mode_reg == gpmc_pkg::PM_FULL && c_forever && main_supply_ok
      |=> ##1 supply_switch_oe && !rx_listen && !nav_en;
   endproperty
   a_forever: assert property (p_forever) else $error("forced backup");
   property p_warmup;
      mode_reg == gpmc_pkg::PM_FULL && c_per && main_supply_ok
      |=> mode_reg == gpmc_pkg::PM_PWARM && iv_reg == 32'(WARMUP_MS);
   endproperty
   a_warmup: assert property (p_warmup) else $error("no warm-up");
   property p_fallback;
      mode_reg == gpmc_pkg::PM_PON && iv_reg == 32'h0 && !fix_valid
      && !c_exit && main_supply_ok
      |=> fb_reg && iv_reg == fb_sleep_reg ##1 fallback_active;
   endproperty
   a_fallback: assert property (p_fallback) else $error("fallback missed");
   property p_exit;
      mode_reg == gpmc_pkg::PM_PSLP && c_exit && main_supply_ok
      |=> mode_reg == gpmc_pkg::PM_FULL;
   endproperty
   a_exit: assert property (p_exit) else $error("periodic exit");
   property p_sleep_cut;
      mode_reg == gpmc_pkg::PM_PSLP && per_bkup_reg |=> supply_switch_oe;
   endproperty
   a_sleep_cut: assert property (p_sleep_cut) else $error("no cut");
   property p_bad_sum;
      rx_valid_reg && ps_reg == gpmc_pkg::PS_LF && ck_rx_reg != ck_calc_reg
      |=> !cmd_reg;
   endproperty
   a_bad_sum: assert property (p_bad_sum) else $error("bad sentence taken");
endmodule // gpmc_top
`default_nettype wire

// File: gpmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpmc_host_model #(
   parameter int BIT_CYCLES = gpmc_pkg::BIT_CYCLES
) (
   input  wire logic core_clk,
   output var logic  uart_rx,
   output var logic  host_supply_enable
);
   initial begin
      uart_rx = 1'b1;
      host_supply_enable = 1'b0; // enable held low
   end

   // 8N1 lsb first at the fixed bit time
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge core_clk) #1 uart_rx = f[i];
         repeat (BIT_CYCLES - 1) @(posedge core_clk);
      end
   endtask

   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction

   // flip corrupts the checksum on purpose
   task automatic send_sent(input string body, input logic [7:0] flip);
      logic [7:0] ck;
      logic [7:0] c;
      ck = 8'h00;
      send_byte(gpmc_pkg::CH_START);
      for (int k = 0; k < 4 + body.len(); k++) begin
         c = (k < 4) ? gpmc_pkg::VND_HDR[31-8*k -: 8] : body[k-4];
         ck = ck ^ c;
         send_byte(c);
      end
      ck = ck ^ flip;
      send_byte(gpmc_pkg::CH_STAR);
      send_byte(hx(ck[7:4]));
      send_byte(hx(ck[3:0]));
      send_byte(gpmc_pkg::CH_CR);
      send_byte(gpmc_pkg::CH_LF);
   endtask

   // raising the enable is the only wake from forced sleep
   task automatic set_en(input logic v);
      @(posedge core_clk) #1 host_supply_enable = v;
   endtask
endmodule // gpmc_host_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       core_clk, resetn, uart_rx, main_gate, main_ok, bk_ok;
   logic       host_en, fix_valid;
   int         aid_count;
   logic       sw_out, sw_oe, rf, nav, nmea, listen, aid, fb;
   logic [2:0] mode;
   int         bad_count;
   int         checked;

   // switch line is pulled up, so main power needs main_gate and either host_en or a released switch
   assign main_ok = main_gate & (host_en | ~sw_oe);

   // shortened bit time keeps the serial traffic within a short run
   localparam int SIM_BIT = 16;

   gpmc_top #(.MS_CYCLES(20), .WARMUP_MS(5), .BIT_CYCLES(SIM_BIT)) u_dut (
      .core_clk(core_clk), .resetn(resetn), .uart_rx(uart_rx),
      .main_supply_ok(main_ok), .backup_supply_ok(bk_ok),
      .host_supply_enable(host_en), .fix_valid(fix_valid),
      .supply_switch_out(sw_out), .supply_switch_oe(sw_oe),
      .rf_power_en(rf), .nav_en(nav), .nmea_en(nmea),
      .rx_listen(listen), .aiding_reuse(aid),
      .fallback_active(fb), .power_mode(mode));

   gpmc_host_model #(.BIT_CYCLES(SIM_BIT)) u_host (
      .core_clk(core_clk), .uart_rx(uart_rx),
      .host_supply_enable(host_en));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // the pulse lasts one cycle, so count it for later judging
   always @(posedge core_clk) if (aid === 1'b1) aid_count++;

   task automatic chk(input logic [3:0] got, input logic [3:0] exp,
                      input string what);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   task automatic wait_mode(input logic [2:0] m, input int lim);
      int n;
      n = 0;
      while (mode !== m && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      repeat (2) @(negedge core_clk);
      chk({1'b0, mode}, {1'b0, m}, "mode");
   endtask

   task automatic t_boot();
      wait_mode(gpmc_pkg::PM_FULL, 20);
      chk({1'b0, rf, nav, nmea}, 4'h7, "full on");
      chk({1'b0, sw_out, sw_oe, listen}, 4'h1, "switch");
      $display("boot done");
   endtask

   task automatic t_badsum();
      u_host.send_sent("161,0", 8'h01);
      repeat (50) @(negedge core_clk);
      chk({1'b0, mode}, 4'h1, "bad sum");
      $display("badsum done");
   endtask

   task automatic t_standby();
      int a0;
      u_host.send_sent("161,0", 8'h00);
      wait_mode(gpmc_pkg::PM_STBY, 50);
      chk({rf, nav, nmea, listen}, 4'h1, "standby");
      a0 = aid_count;
      u_host.send_byte(8'h55);
      wait_mode(gpmc_pkg::PM_FULL, 3000);
      chk({2'h0, aid_count == a0 + 1, rf}, 4'h3, "wake");
      $display("standby done");
   endtask

   task automatic t_forced();
      int a0;
      u_host.send_sent("225,4", 8'h00);
      wait_mode(gpmc_pkg::PM_BKUP, 50);
      chk({sw_oe, main_ok, listen, rf}, 4'h8, "backup");
      repeat (100) @(negedge core_clk);
      chk({1'b0, mode}, 4'h3, "stays");
      a0 = aid_count;
      u_host.set_en(1'b1);
      wait_mode(gpmc_pkg::PM_FULL, 50);
      chk({2'h0, aid_count == a0 + 1, sw_oe}, 4'h2, "woken");
      u_host.set_en(1'b0);
      $display("forced done");
   endtask

   task automatic t_unforced();
      @(posedge core_clk) #1 main_gate = 1'b0;
      wait_mode(gpmc_pkg::PM_BKUP, 20);
      @(posedge core_clk) #1 main_gate = 1'b1;
      wait_mode(gpmc_pkg::PM_FULL, 20);
      @(posedge core_clk) #1 main_gate = 1'b0;
      bk_ok = 1'b0;
      wait_mode(gpmc_pkg::PM_OFF, 20);
      @(posedge core_clk) #1 main_gate = 1'b1;
      bk_ok = 1'b1;
      wait_mode(gpmc_pkg::PM_FULL, 20);
      $display("unforced done");
   endtask

   task automatic t_pstandby();
      u_host.send_sent("225,2,2,2,3,3", 8'h00);
      wait_mode(gpmc_pkg::PM_PWARM, 50);
      @(posedge core_clk) #1 fix_valid = 1'b0;
      wait_mode(gpmc_pkg::PM_PON, 200);
      wait_mode(gpmc_pkg::PM_PSLP, 80);
      chk({fb, listen, rf, sw_oe}, 4'hC, "fallback");
      @(posedge core_clk) #1 fix_valid = 1'b1;
      wait_mode(gpmc_pkg::PM_PON, 120);
      wait_mode(gpmc_pkg::PM_PSLP, 100);
      chk({3'h0, fb}, 4'h0, "primary");
      u_host.send_sent("225,0", 8'h00);
      wait_mode(gpmc_pkg::PM_FULL, 60);
      $display("periodic standby done");
   endtask

   task automatic t_pbackup();
      u_host.send_sent("225,1,150,2,150,2", 8'h00);
      wait_mode(gpmc_pkg::PM_PWARM, 50);
      wait_mode(gpmc_pkg::PM_PON, 200);
      chk({2'h0, sw_oe, rf}, 4'h1, "on interval");
      wait_mode(gpmc_pkg::PM_PSLP, 3100);
      chk({main_ok, listen, rf, sw_oe}, 4'h1, "backup sleep");
      wait_mode(gpmc_pkg::PM_PON, 80);
      u_host.send_sent("225,0", 8'h00);
      wait_mode(gpmc_pkg::PM_FULL, 60);
      $display("periodic backup done");
   endtask

   task automatic conclude();
      $display("checked %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      resetn = 1'b0;
      main_gate = 1'b1;
      bk_ok = 1'b1;
      fix_valid = 1'b1;
      bad_count = 0;
      checked = 0;
      repeat (12) @(posedge core_clk);
      #1 resetn = 1'b1;
      t_boot();
      t_badsum();
      t_standby();
      t_forced();
      t_unforced();
      t_pstandby();
      t_pbackup();
      conclude();
   end

   // some 130 bytes at the short bit time plus the intervals: ~24,000 cycles
   initial begin
      #3_000_000;
      bad_count++;
      conclude();
   end
endmodule // tb
`default_nettype wire
